// [rtl/leil_top.sv]
// Line event interrupt logic with serial register port
// How it works
// - Each interrupt source owns one flag bit of the source register.
// - Reading the source register returns flags, clears them, releases the pin.
// - A PCM clock fault sets source bit 4.
// - A line condition fault sets source bit 2.
// - Loss of barrier sync sets source bit 1.
// - AC level above the threshold field sets ring detect and ring monitor.
// - Each expansion pin flag rises only with its own enable bit.
// - Each expansion pin triggers on the level its polarity bit selects.
// - Enable bit 4 gates the clock fault flag.
// - Enable bit 2 gates the line fault flag.
// - Enable bit 1 gates the sync loss flag.
// - Enable bit 0 gates ring detect and ring monitor together.
// - Line fault indications only count while off hook.
// - Line voltage sits in bits 7 to 1; bit 0 reads zero.
// - PLL reset clears a transient clock fault; lasting clock loss reasserts.
// - Read clears ring detect; ring monitor holds while over and 25 ms after.
`timescale 1ns/10ps
`default_nettype none
module leil_top #(
    parameter int RING_HOLD_CYCLES = leil_pkg::RING_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Serial register port
    input wire logic SPI_SCLK_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_SDI_I,
    output logic SPI_SDO_O,
    output logic SPI_SDO_OE_O,
    // Event sources
    input wire logic [2:0] PIN_IRQ_I,
    input wire logic PCM_CLOCK_FAULT_I,
    input wire logic PLL_RESET_I,
    input wire logic SYNC_LOSS_I,
    input wire leil_pkg::leil_cause_t LINE_CAUSE_I,
    input wire logic [7:0] LINE_AC_LEVEL_I,
    input wire logic [6:0] LINE_VOLTAGE_I,
    // Interrupt and line control
    output logic IRQ_N_O,
    output logic OFF_HOOK_O,
    output logic DC_PATH_EN_O,
    output logic AC_PATH_EN_O
);
    import leil_pkg::*;

    // Refuse a hold too short for the ring monitor window to be seen
    if (RING_HOLD_CYCLES < 4) begin : g_bad_ring_hold
        $error("RING_HOLD_CYCLES must be at least four");
    end

    // Serial port state
    logic sclk_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] shin_q;
    logic [7:0] cmd_q;
    logic [7:0] tx_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cmd_load;
    logic [7:0] cmd_d;
    logic wr_stb;
    logic rd_clr;
    logic [7:0] rd_data;
    logic [7:0] wr_data;

    // Software registers
    logic [7:0] en_q;
    logic [2:0] polarity_q;
    logic [1:0] rth_q;
    logic [7:0] hook_q;
    logic [7:0] fde_q;
    logic [7:0] volt_q;
    logic [7:0] cause_q;

    // Flags and event sources
    leil_src_t flags_q;
    leil_src_t flags_d;
    leil_src_t set_vec;
    logic [7:0] irq_map;
    logic [7:0] irq_map_d;
    logic exceed;
    logic exceed_q;
    logic ring_rise;
    logic hold_active;
    logic line_fault_cond;
    logic mon_latch_q;

    // Edge detection on the serial clock, sampled as a plain synchronous input
    assign sclk_rise = SPI_SCLK_I && !sclk_q;
    assign sclk_fall = !SPI_SCLK_I && sclk_q;
    assign cmd_d = {shin_q[6:0], SPI_SDI_I};
    assign cmd_load = !SPI_CS_N_I && sclk_rise && (bit_cnt_q == SPI_CMD_BITS - 5'd1);
    assign wr_data = cmd_d;
    assign wr_stb = !SPI_CS_N_I && sclk_rise && !cmd_q[7]
        && (bit_cnt_q == SPI_FRAME_BITS - 5'd1);
    assign rd_clr = cmd_load && cmd_d[7] && (cmd_d[6:0] == ADDR_SRC_FLAGS);

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= SPI_SCLK_I;
        end
    end

    // Bit counter and input shifter; extra clocks past the frame are ignored
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            bit_cnt_q <= '0;
            shin_q <= '0;
            cmd_q <= '0;
        end else if (SPI_CS_N_I) begin
            bit_cnt_q <= '0;
        end else if (sclk_rise && bit_cnt_q != SPI_FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'd1;
            shin_q <= cmd_d;
            if (cmd_load) begin
                cmd_q <= cmd_d;
            end
        end
    end

    // Read multiplexer, indexed by the address just received
    always_comb begin
        rd_data = 8'h00;
        unique case (cmd_d[6:0])
            ADDR_SRC_FLAGS: rd_data = flags_q;
            ADDR_EN_MASK: rd_data = en_q;
            ADDR_PIN_POLARITY: rd_data = {polarity_q, 5'h00};
            ADDR_RING_TH: rd_data = {6'h00, rth_q};
            ADDR_HOOK_CTRL: rd_data = hook_q;
            ADDR_FAULT_EN: rd_data = fde_q;
            ADDR_LINE_VOLT: rd_data = volt_q;
            ADDR_FAULT_CAUSE: rd_data = cause_q;
            default: rd_data = 8'h00;
        endcase
    end

    // Output shifter: loaded after the command byte, shifted on falling edges
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tx_q <= '0;
            SPI_SDO_OE_O <= 1'b0;
        end else if (SPI_CS_N_I) begin
            SPI_SDO_OE_O <= 1'b0;
        end else if (cmd_load) begin
            tx_q <= cmd_d[7] ? rd_data : 8'h00;
            SPI_SDO_OE_O <= cmd_d[7];
        end else if (sclk_fall && bit_cnt_q > SPI_CMD_BITS) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign SPI_SDO_O = tx_q[7];

    // Writable registers; the source register ignores writes
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            en_q <= RST_EN_MASK;
            polarity_q <= RST_PIN_POLARITY[7:5];
            rth_q <= RST_RING_TH;
            hook_q <= RST_HOOK_CTRL;
            fde_q <= RST_FAULT_EN;
        end else if (wr_stb) begin
            unique case (cmd_q[6:0])
                ADDR_EN_MASK: en_q <= wr_data;
                ADDR_PIN_POLARITY: polarity_q <= wr_data[7:5];
                ADDR_RING_TH: rth_q <= wr_data[1:0];
                ADDR_HOOK_CTRL: hook_q <= wr_data;
                ADDR_FAULT_EN: fde_q <= wr_data;
                default: ;
            endcase
        end
    end

    // Line side readings; bit 0 of the voltage reading is reserved and zero
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            volt_q <= 8'h00;
            cause_q <= 8'h00;
        end else begin
            volt_q <= {LINE_VOLTAGE_I, 1'b0};
            cause_q <= {1'b0, LINE_CAUSE_I, 3'h0};
        end
    end

    // Line control outputs follow the hook control register
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            OFF_HOOK_O <= 1'b0;
            DC_PATH_EN_O <= 1'b0;
            AC_PATH_EN_O <= 1'b0;
        end else begin
            OFF_HOOK_O <= hook_q[POS_OFF_HOOK];
            DC_PATH_EN_O <= hook_q[POS_DC_PATH];
            AC_PATH_EN_O <= hook_q[POS_AC_PATH];
        end
    end

    // Ring threshold compare and crossing detection
    assign exceed = LINE_AC_LEVEL_I > RING_TH_LEVEL[rth_q];
    assign ring_rise = exceed && !exceed_q;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            exceed_q <= 1'b0;
        end else begin
            exceed_q <= exceed;
        end
    end

    leil_ring_hold #(
        .HOLD_CYCLES(RING_HOLD_CYCLES)
    ) u_ring_hold (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .exceed_i(exceed),
        .active_o(hold_active)
    );

    // A line fault only counts while off hook; on hook the causes are noise
    assign line_fault_cond = hook_q[POS_OFF_HOOK] && (
        (LINE_CAUSE_I.undervoltage_cause && fde_q[POS_EN_UNDERV])
        || (LINE_CAUSE_I.overvoltage_cause && fde_q[POS_EN_OVERV])
        || (LINE_CAUSE_I.overcurrent_cause && fde_q[POS_EN_OVERI])
        || (LINE_CAUSE_I.overload_cause && fde_q[POS_EN_OVERLOAD]));

    // Per pin: trigger level chosen by polarity, gated by its own enable
    for (genvar g = 0; g < 3; g++) begin : g_pin
        assign set_vec.pin_irq[g] = en_q[POS_PIN_LO + g]
            && (PIN_IRQ_I[g] == polarity_q[g]);
    end

    // Level sources set every cycle they persist, so a lasting fault reasserts
    assign set_vec.pcm_clock_fault_flag = PCM_CLOCK_FAULT_I && en_q[POS_CLK_FAULT];
    assign set_vec.line_fault_flag = line_fault_cond && en_q[POS_LINE_FAULT];
    assign set_vec.barrier_sync_loss_flag = SYNC_LOSS_I && en_q[POS_SYNC_LOSS];
    assign set_vec.ring_detect_flag = ring_rise && en_q[POS_RING];
    assign set_vec.ring_monitor_flag = ring_rise && en_q[POS_RING];

    // Latched part of ring monitor; the visible bit also shows the hold window
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mon_latch_q <= 1'b0;
        end else begin
            mon_latch_q <= set_vec.ring_monitor_flag || (mon_latch_q && !rd_clr);
        end
    end

    // Flag update: a set in the clearing cycle wins, so no event is lost
    always_comb begin
        flags_d = rd_clr ? '0 : flags_q;
        flags_d = flags_d | set_vec;
        flags_d.ring_monitor_flag = set_vec.ring_monitor_flag
            || (mon_latch_q && !rd_clr) || (hold_active && en_q[POS_RING]);
        if (PLL_RESET_I && !set_vec.pcm_clock_fault_flag) begin
            flags_d.pcm_clock_fault_flag = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Ring enable covers both ring bits; bit 3 of the mask is auto-poll, not an enable
    assign irq_map = {en_q[7:4], en_q[POS_RING], en_q[2:0]};
    assign irq_map_d = (wr_stb && cmd_q[6:0] == ADDR_EN_MASK)
        ? {wr_data[7:4], wr_data[POS_RING], wr_data[2:0]} : irq_map;

    // Active low pin from the next flag and mask values, so it tracks them exactly
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            IRQ_N_O <= 1'b1;
        end else begin
            IRQ_N_O <= !(|(flags_d & irq_map_d));
        end
    end

    chk_irq_tracks_flags: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        IRQ_N_O == !(|(flags_q & irq_map))) else $error("interrupt pin disagrees with flags");

    chk_read_clears_ring: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        rd_clr && !set_vec.ring_detect_flag |=> !flags_q.ring_detect_flag)
        else $error("ring detect survived a source read");

    chk_read_then_idle: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        rd_clr && set_vec == '0 && !hold_active |=> flags_q == '0 ##0 IRQ_N_O)
        else $error("source read did not clear flags");

    chk_clock_fault_set: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        PCM_CLOCK_FAULT_I && en_q[4] |=> flags_q[4]) else $error("clock fault not flagged");

    chk_pll_clears: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        PLL_RESET_I && !PCM_CLOCK_FAULT_I |=> !flags_q[4]) else $error("pll reset left clock fault");

    chk_line_fault_hook: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !flags_q[2] && !hook_q[7] |=> !flags_q[2]) else $error("line fault raised on hook");

    chk_sync_loss_set: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        SYNC_LOSS_I && en_q[1] |=> flags_q[1]) else $error("sync loss not flagged");

    chk_ring_pair: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        ring_rise && en_q[0] |=> flags_q[0] && flags_q[3] ##1 flags_q[3])
        else $error("ring crossing did not set both ring bits");

    chk_pin_enable: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !en_q[5] && !flags_q[5] |=> !flags_q[5]) else $error("disabled pin raised a flag");

    chk_pin_polarity: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        en_q[5] && PIN_IRQ_I[0] == polarity_q[0] |=> flags_q[5]) else $error("pin level not flagged");

    chk_volt_bit0: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        cmd_load && cmd_d == {1'b1, ADDR_LINE_VOLT} |=> tx_q[0] == 1'b0 && SPI_SDO_OE_O)
        else $error("voltage reserved bit not zero");

    // Raising checked on the interrupt pin alone, latching checked on the flag vector itself
    chk_irq_on_set: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (set_vec & irq_map) != 8'h00 && !wr_stb |=> !IRQ_N_O)
        else $error("enabled event did not raise the interrupt");

    chk_flags_latch: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !rd_clr |=> (flags_q & $past(flags_q) & 8'he7) == ($past(flags_q) & 8'he7))
        else $error("latched flag lost without a read");

    chk_line_fault_set: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        line_fault_cond && en_q[POS_LINE_FAULT] |=> flags_q.line_fault_flag)
        else $error("line fault not flagged");

    chk_monitor_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        hold_active && en_q[POS_RING] |=> flags_q.ring_monitor_flag)
        else $error("ring monitor dropped inside the hold window");
endmodule // leil_top
`default_nettype wire

// [rtl/leil_pkg.sv]
// Shared constants and types of the line event interrupt logic
package leil_pkg;
    // Register offsets on the serial register port
    localparam logic [6:0] ADDR_SRC_FLAGS = 7'h03;
    localparam logic [6:0] ADDR_EN_MASK = 7'h05;
    localparam logic [6:0] ADDR_PIN_POLARITY = 7'h06;
    localparam logic [6:0] ADDR_RING_TH = 7'h0e;
    localparam logic [6:0] ADDR_HOOK_CTRL = 7'h12;
    localparam logic [6:0] ADDR_FAULT_EN = 7'h15;
    localparam logic [6:0] ADDR_LINE_VOLT = 7'h1b;
    localparam logic [6:0] ADDR_FAULT_CAUSE = 7'h1e;
    // Reset values
    localparam logic [7:0] RST_EN_MASK = 8'h00;
    localparam logic [7:0] RST_PIN_POLARITY = 8'h00;
    localparam logic [1:0] RST_RING_TH = 2'h0;
    localparam logic [7:0] RST_HOOK_CTRL = 8'h00;
    localparam logic [7:0] RST_FAULT_EN = 8'h00;
    // Field positions
    localparam int POS_PIN_LO = 5;
    localparam int POS_CLK_FAULT = 4;
    localparam int POS_AUTO_POLL = 3;
    localparam int POS_LINE_FAULT = 2;
    localparam int POS_SYNC_LOSS = 1;
    localparam int POS_RING = 0;
    localparam int POS_OFF_HOOK = 7;
    localparam int POS_DC_PATH = 6;
    localparam int POS_AC_PATH = 5;
    localparam int POS_EN_OVERLOAD = 7;
    localparam int POS_EN_UNDERV = 2;
    localparam int POS_EN_OVERV = 1;
    localparam int POS_EN_OVERI = 0;
    // Serial frame: one command byte (bit 7 set for read), one data byte
    localparam logic [4:0] SPI_CMD_BITS = 5'd8;
    localparam logic [4:0] SPI_FRAME_BITS = 5'd16;
    // Ring threshold levels selected by the two-bit threshold field
    localparam logic [7:0] RING_TH_LEVEL [4] = '{8'h40, 8'h60, 8'h80, 8'ha0};
    // Ring monitor hold time after the line crosses back
    localparam int CLK_MHZ = 250;
    localparam int RING_HOLD_MS = 25;
    localparam int RING_HOLD_CYCLES = RING_HOLD_MS * CLK_MHZ * 1000;
    // Interrupt source flags, one dedicated bit each
    typedef struct packed {
        logic [2:0] pin_irq;
        logic pcm_clock_fault_flag;
        logic ring_monitor_flag;
        logic line_fault_flag;
        logic barrier_sync_loss_flag;
        logic ring_detect_flag;
    } leil_src_t;
    // Line fault causes reported by the line side
    typedef struct packed {
        logic undervoltage_cause;
        logic overvoltage_cause;
        logic overcurrent_cause;
        logic overload_cause;
    } leil_cause_t;
endpackage

// [rtl/leil_ring_hold.sv]
// Ring monitor hold timer: active while over threshold and a hold time after
`timescale 1ns/10ps
`default_nettype none
module leil_ring_hold #(
    parameter int HOLD_CYCLES = 6250000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Level in and held level out
    input wire logic exceed_i,
    output logic active_o
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    // Refuse a hold that cannot be counted
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least one");
    end

    logic [CW-1:0] cnt_q;

    // Reload while over threshold, then count down the hold window
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (exceed_i) begin
            cnt_q <= CW'(HOLD_CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    // A new crossing inside the window restarts the hold, so no gap appears
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_o <= 1'b0;
        end else begin
            active_o <= exceed_i || (cnt_q > CW'(1));
        end
    end

    chk_hold_after_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(exceed_i) |-> active_o [*4]) else $error("ring monitor dropped too early");
endmodule // leil_ring_hold
`default_nettype wire

// [sim/leil_host_model.sv]
// Host processor model that runs frames on the serial register port
`timescale 1ns/10ps
`default_nettype none
module leil_host_model (
    // Clock
    input wire logic clk_i,
    // Serial port pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i
);
    import leil_pkg::*;
    // Four samples per phase, since the port samples the serial clock as a plain synchronous input
    localparam int HALF = 4;
    // Span that separates a polarity reversal from a ring burst, in microseconds
    localparam int RING_SPAN_US = 150000;
    logic oe_seen;
    logic [7:0] saved_source_flags;
    logic [7:0] saved_enable_mask;
    logic [7:0] last_cause;

    // Idle pins before any frame
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        last_cause = 8'h00;
        oe_seen = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Command byte then data byte, msb first; read bits are taken just before each late rise
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
        logic [15:0] frame;
        frame = {cmd, wdat};
        rdat = 8'h00;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi_o = frame[i];
            wait_cyc(HALF);
            if (i < 8) begin
                rdat = {rdat[6:0], sdo_i};
                oe_seen = sdo_oe_i;
            end
            sclk_o = 1'b1;
            wait_cyc(HALF);
            sclk_o = 1'b0;
        end
        wait_cyc(HALF);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // Released line must not keep its last bit
        wait_cyc(HALF);
    endtask

    task automatic reg_write(input logic [6:0] addr, input logic [7:0] val);
        logic [7:0] unused;
        xfer({1'b0, addr}, val, unused);
    endtask

    task automatic reg_read(input logic [6:0] addr, output logic [7:0] val);
        xfer({1'b1, addr}, 8'h00, val);
    endtask

    // Going on hook touches only the top three control bits
    task automatic go_on_hook();
        logic [7:0] ctl;
        reg_read(ADDR_HOOK_CTRL, ctl);
        reg_write(ADDR_HOOK_CTRL, ctl & 8'h1f);
    endtask

    // Interrupt service; a line fault only counts while the line is off hook
    task automatic service(output logic [7:0] flags);
        logic [7:0] ctl;
        reg_read(ADDR_SRC_FLAGS, saved_source_flags);
        reg_read(ADDR_EN_MASK, saved_enable_mask);
        reg_write(ADDR_EN_MASK, saved_enable_mask | 8'h08);
        reg_read(ADDR_HOOK_CTRL, ctl);
        if (saved_source_flags[POS_LINE_FAULT] && ctl[POS_OFF_HOOK]) begin
            reg_read(ADDR_FAULT_CAUSE, last_cause);
            if (last_cause[6:3] != 4'h0) begin
                go_on_hook();
            end
        end
        reg_write(ADDR_EN_MASK, saved_enable_mask);
        flags = saved_source_flags;
    endtask

    // Ring timer expiry: a short first-to-last span means polarity reversal
    task automatic ring_expire(input int first_us, input int last_us, input int count,
            output logic burst, output int freq_hz);
        burst = (last_us - first_us) >= RING_SPAN_US;
        freq_hz = burst ? (2 * count * 1000000) / (last_us - first_us) : 0;
    endtask
endmodule // leil_host_model
`default_nettype wire

// [sim/line_event_interrupt_logic_tb.sv]
// Self-checking testbench of the line event interrupt logic
`timescale 1ns/10ps
`default_nettype none
module line_event_interrupt_logic_tb;
    import leil_pkg::*;
    localparam int HOLD = 200;
    localparam int LIMIT = 30000;
    logic sys_clk, rst, sclk, cs_n, sdi, sdo, sdo_oe, pcm_fault, pll_reset, sync_loss;
    logic irq_n, off_hook, dc_en, ac_en;
    logic [2:0] pin_irq;
    leil_cause_t line_cause;
    logic [7:0] ac_level, rd, a_val;
    logic [6:0] line_volt;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    int freq;

    leil_top #(.RING_HOLD_CYCLES(HOLD)) uut (.SYS_CLK_I(sys_clk), .RST_I(rst), .SPI_SCLK_I(sclk),
        .SPI_CS_N_I(cs_n), .SPI_SDI_I(sdi), .SPI_SDO_O(sdo), .SPI_SDO_OE_O(sdo_oe), .PIN_IRQ_I(pin_irq),
        .PCM_CLOCK_FAULT_I(pcm_fault), .PLL_RESET_I(pll_reset), .SYNC_LOSS_I(sync_loss),
        .LINE_CAUSE_I(line_cause), .LINE_AC_LEVEL_I(ac_level), .LINE_VOLTAGE_I(line_volt),
        .IRQ_N_O(irq_n), .OFF_HOOK_O(off_hook), .DC_PATH_EN_O(dc_en), .AC_PATH_EN_O(ac_en));
    leil_host_model host (.clk_i(sys_clk), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe));

    // Clock; a hang is cut short by the cycle ceiling
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Writable registers come up cleared, an unmapped place reads zero
    task automatic t_reset();
        logic [6:0] addrs [5] = '{ADDR_EN_MASK, ADDR_PIN_POLARITY, ADDR_RING_TH, ADDR_HOOK_CTRL, ADDR_FAULT_EN};
        check({7'h00, irq_n}, 8'h01);
        foreach (addrs[i]) begin
            host.reg_read(addrs[i], rd);
            check(rd, 8'h00);
        end
        host.reg_read(7'h20, rd);
        check(rd, 8'h00);
    endtask

    // Sync loss is gated by its enable, then latched and cleared by the service read
    task automatic t_sync();
        sync_loss = 1'b1;
        @(negedge sys_clk);
        sync_loss = 1'b0;
        settle();
        check({7'h00, irq_n}, 8'h01);
        host.reg_write(ADDR_EN_MASK, 8'h02);
        sync_loss = 1'b1;
        @(negedge sys_clk);
        sync_loss = 1'b0;
        settle();
        check({7'h00, irq_n}, 8'h00);
        host.service(rd);
        check(rd, 8'h02);
        check({7'h00, irq_n}, 8'h01);
        pll_reset = 1'b1;
        @(negedge sys_clk);
        pll_reset = 1'b0;
    endtask

    // Clock fault: a transient one goes with a PLL reset, a lasting one stays
    task automatic t_clock();
        host.reg_write(ADDR_EN_MASK, 8'h10);
        pcm_fault = 1'b1;
        @(negedge sys_clk);
        pcm_fault = 1'b0;
        settle();
        check({7'h00, irq_n}, 8'h00);
        pll_reset = 1'b1;
        @(negedge sys_clk);
        pll_reset = 1'b0;
        settle();
        check({7'h00, irq_n}, 8'h01);
        pcm_fault = 1'b1;
        settle();
        pll_reset = 1'b1;
        @(negedge sys_clk);
        pll_reset = 1'b0;
        settle();
        check({7'h00, irq_n}, 8'h00);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(rd, 8'h10);
        pcm_fault = 1'b0;
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check({7'h00, irq_n}, 8'h01);
    endtask

    // Line fault counts only off hook; the host reads the cause and goes on hook
    task automatic t_line();
        host.reg_write(ADDR_EN_MASK, 8'h04);
        host.reg_write(ADDR_FAULT_EN, 8'h87);
        host.reg_write(ADDR_HOOK_CTRL, 8'h03);
        line_cause = 4'b0100;
        settle();
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(rd, 8'h00);
        line_cause = 4'b0000;
        host.reg_write(ADDR_HOOK_CTRL, 8'he3);
        settle();
        check({5'h00, off_hook, dc_en, ac_en}, 8'h07);
        line_cause = 4'b0100;
        settle();
        check({7'h00, irq_n}, 8'h00);
        host.service(rd);
        check(rd, 8'h04);
        check(host.last_cause, 8'h20);
        host.reg_read(ADDR_HOOK_CTRL, rd);
        check(rd, 8'h03);
        check({5'h00, off_hook, dc_en, ac_en}, 8'h00);
        line_cause = 4'b0000;
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check({7'h00, irq_n}, 8'h01);
    endtask

    // Ring: strictly above threshold, detect cleared by read, monitor held after the drop
    task automatic t_ring();
        host.reg_write(ADDR_RING_TH, 8'hfe);
        host.reg_read(ADDR_RING_TH, rd);
        check(rd, 8'h02);
        host.reg_write(ADDR_EN_MASK, 8'h01);
        ac_level = 8'h80;
        settle();
        check({7'h00, irq_n}, 8'h01);
        ac_level = 8'h81;
        settle();
        check({7'h00, irq_n}, 8'h00);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(rd, 8'h09);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(rd, 8'h08);
        ac_level = 8'h00;
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(rd, 8'h08);
        repeat (HOLD + 50) @(negedge sys_clk);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(rd, 8'h00);
        host.ring_expire(0, 100000, 1, a_val[0], freq);
        check({7'h00, a_val[0]}, 8'h00);
        host.ring_expire(0, 2000000, 80, a_val[0], freq);
        check({7'h00, a_val[0]}, 8'h01);
        check(freq[7:0], 8'h50);
    endtask

    // Line voltage sits above a zero bit; read-only places ignore writes
    task automatic t_volt();
        line_volt = 7'h55;
        settle();
        host.reg_read(ADDR_LINE_VOLT, rd);
        check(rd, 8'haa);
        check({7'h00, host.oe_seen}, 8'h01);
        host.reg_write(ADDR_LINE_VOLT, 8'h11);
        check({7'h00, host.oe_seen}, 8'h00);
        host.reg_read(ADDR_LINE_VOLT, rd);
        check(rd, 8'haa);
        host.reg_write(ADDR_SRC_FLAGS, 8'hff);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(rd, 8'h00);
    endtask

    // Pins held high: the two polarities give complementary flags, only enabled pins show
    task automatic t_pins();
        pin_irq = 3'b111;
        host.reg_write(ADDR_EN_MASK, 8'ha0);
        host.reg_write(ADDR_PIN_POLARITY, 8'h00);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        host.reg_read(ADDR_SRC_FLAGS, a_val);
        host.reg_write(ADDR_PIN_POLARITY, 8'hff);
        host.reg_read(ADDR_PIN_POLARITY, rd);
        check(rd, 8'he0);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        host.reg_read(ADDR_SRC_FLAGS, rd);
        check(a_val ^ rd, 8'ha0);
        check(a_val & rd, 8'h00);
    endtask

    // Inputs at time zero, reset for ten cycles, then the scenarios
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        pin_irq = 3'b000;
        pcm_fault = 1'b0;
        pll_reset = 1'b0;
        sync_loss = 1'b0;
        line_cause = 4'b0000;
        ac_level = 8'h00;
        line_volt = 7'h00;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_sync();
        t_clock();
        t_line();
        t_ring();
        t_volt();
        t_pins();
        final_report();
    end
endmodule // line_event_interrupt_logic_tb
`default_nettype wire
